// ==== logic/cmpc_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmpc_top
   import cmpc_pkg::*;
#(
   parameter int unsigned LVL_W = LEVEL_W
)
(
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RSTN_I,
   // register port
   input wire logic [1:0] ADDR_I,
   input wire logic [7:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [7:0] RDATA_O,
   // digitised analog levels
   input wire logic [LVL_W-1:0] POS_LEVEL_I,
   input wire logic [LVL_W-1:0] NEG_LEVEL_I,
   input wire logic [LVL_W-1:0] CH0_LEVEL_I,
   input wire logic [LVL_W-1:0] CH1_LEVEL_I,
   input wire logic [LVL_W-1:0] CH2_LEVEL_I,
   input wire logic [LVL_W-1:0] CH3_LEVEL_I,
   // converter state
   input wire logic CONV_ENABLE_I,
   input wire logic [1:0] CHAN_SEL_I,
   // processor
   input wire logic GLOBAL_IRQ_EN_I,
   input wire logic IRQ_ACK_I,
   output logic IRQ_REQ_O,
   // pins and status
   input wire logic [1:0] PIN_DIG_I,
   output logic [1:0] PIN_READ_O,
   output logic RESULT_O
);

   // ***********************************************************
   // state
   // ***********************************************************
   cmpc_state_t q;
   cmpc_state_t d;
   cmpc_bus_t bus;
   logic [LVL_W-1:0] pos_v;
   logic [LVL_W-1:0] neg_v;
   logic raw_cmp;
   logic synced;
   logic evt;
   logic csr_wr;

   assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};
   assign csr_wr = bus.wr && (bus.addr == ADDR_CSR);

   // ***********************************************************
   // input selection and comparison
   // ***********************************************************
   always_comb begin
      pos_v = POS_LEVEL_I;
      if (q.bg_sel) begin
         pos_v = LVL_W'(BANDGAP_LEVEL);
      end
      neg_v = NEG_LEVEL_I;
      // converter multiplexer is only free while converter is off
      if (q.mux_sel && !CONV_ENABLE_I) begin
         unique case (CHAN_SEL_I)
            2'h0: neg_v = CH0_LEVEL_I;
            2'h1: neg_v = CH1_LEVEL_I;
            2'h2: neg_v = CH2_LEVEL_I;
            2'h3: neg_v = CH3_LEVEL_I;
         endcase
      end
      // powered off comparator outputs low; may glitch an edge event
      raw_cmp = !q.pwr_off && (pos_v > neg_v);
   end

   cmpc_sync u_sync (
      .clk_i(CLOCK_I),
      .rstn_i(RSTN_I),
      .async_i(raw_cmp),
      .sync_o(synced)
   );

   cmpc_edge u_edge (
      .clk_i(CLOCK_I),
      .rstn_i(RSTN_I),
      .sample_i(synced),
      .mode_i(q.mode),
      .event_o(evt)
   );

   // ***********************************************************
   // registers
   // ***********************************************************
   always_comb begin
      d = q;
      d.rdata = 8'h00;
      if (bus.wr) begin
         unique case (bus.addr)
            ADDR_CTRL_B: begin
               d.mux_sel = bus.wdata[CTRLB_MUX_BIT];
               d.trig = bus.wdata[CTRLB_TRIG_LO+:3];
            end
            ADDR_CSR: begin
               d.pwr_off = bus.wdata[CSR_PWR_BIT];
               d.bg_sel = bus.wdata[CSR_BG_BIT];
               d.ien = bus.wdata[CSR_IEN_BIT];
               d.mode = cmpc_mode_t'(bus.wdata[CSR_MODE_LO+:2]);
               if (bus.wdata[CSR_FLAG_BIT]) begin
                  d.flag = 1'b0;
               end
            end
            ADDR_DIDR: begin
               d.didr = bus.wdata[DIDR_W-1:0];
            end
            default: begin
            end
         endcase
      end
      if (IRQ_ACK_I) begin
         d.flag = 1'b0;
      end
      // a new event outranks any clear in the same cycle
      if (evt) begin
         d.flag = 1'b1;
      end
      if (bus.rd) begin
         unique case (bus.addr)
            ADDR_CTRL_B: begin
               d.rdata[CTRLB_MUX_BIT] = q.mux_sel;
               d.rdata[CTRLB_TRIG_LO+:3] = q.trig;
            end
            ADDR_CSR: begin
               d.rdata[CSR_PWR_BIT] = q.pwr_off;
               d.rdata[CSR_BG_BIT] = q.bg_sel;
               d.rdata[CSR_RES_BIT] = synced;
               d.rdata[CSR_FLAG_BIT] = q.flag;
               d.rdata[CSR_IEN_BIT] = q.ien;
               d.rdata[CSR_MODE_LO+:2] = q.mode;
            end
            ADDR_DIDR: begin
               d.rdata[DIDR_W-1:0] = q.didr;
            end
            default: begin
               d.rdata = 8'h00;
            end
         endcase
      end
      d.irq_req = q.flag && q.ien && GLOBAL_IRQ_EN_I;
      d.pin_rd[DIDR_NEG_BIT] = PIN_DIG_I[DIDR_NEG_BIT]
         && !q.didr[DIDR_NEG_BIT];
      d.pin_rd[DIDR_POS_BIT] = PIN_DIG_I[DIDR_POS_BIT]
         && !q.didr[DIDR_POS_BIT];
   end

   always_ff @(posedge CLOCK_I) begin
      if (!RSTN_I) begin
         q <= '{mux_sel: 1'b0, trig: TRIG_RST, pwr_off: 1'b0,
                bg_sel: 1'b0, flag: 1'b0, ien: 1'b0,
                mode: CMPC_MODE_TOGGLE, didr: DIDR_RST,
                rdata: 8'h00, irq_req: 1'b0, pin_rd: 2'h0};
      end else begin
         q <= d;
      end
   end

   assign RDATA_O = q.rdata;
   assign IRQ_REQ_O = q.irq_req;
   assign PIN_READ_O = q.pin_rd;
   assign RESULT_O = synced;

   // ***********************************************************
   // checks
   // ***********************************************************
   default clocking cb @(posedge CLOCK_I);
   endclocking
   default disable iff (!RSTN_I);

   sequence s_csr_write;
      WR_I && (ADDR_I == ADDR_CSR);
   endsequence

   sequence s_flag_clear_req;
      (s_csr_write and WDATA_I[CSR_FLAG_BIT]) or IRQ_ACK_I;
   endsequence

   // both sync stages must have left reset before the result is valid
   property p_compare;
      ($past(RSTN_I, 2) && $past(RSTN_I)) |-> RESULT_O ==
         $past(!q.pwr_off && (pos_v > neg_v), 2);
   endproperty
   a_compare: assert property (p_compare)
      else $error("result does not follow the input comparison");

   property p_neg_mux;
      (q.mux_sel && !CONV_ENABLE_I && CHAN_SEL_I == 2'h3)
         |-> neg_v == CH3_LEVEL_I;
   endproperty
   a_neg_mux: assert property (p_neg_mux)
      else $error("channel three not used as negative input");

   property p_neg_pin;
      (!q.mux_sel || CONV_ENABLE_I) |-> neg_v == NEG_LEVEL_I;
   endproperty
   a_neg_pin: assert property (p_neg_pin)
      else $error("negative pin not used as negative input");

   property p_bandgap;
      q.bg_sel |-> pos_v == LVL_W'(BANDGAP_LEVEL);
   endproperty
   a_bandgap: assert property (p_bandgap)
      else $error("bandgap not used as positive input");

   property p_sync;
      $rose(raw_cmp) ##1 raw_cmp |=> RESULT_O;
   endproperty
   a_sync: assert property (p_sync)
      else $error("result late after synchroniser");

   property p_flag_set;
      evt |=> q.flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("event did not set the flag");

   property p_rsvd_mode;
      (q.mode == CMPC_MODE_RSVD) |-> !evt;
   endproperty
   a_rsvd_mode: assert property (p_rsvd_mode)
      else $error("reserved mode produced an event");

   property p_request;
      IRQ_REQ_O == $past(q.flag && q.ien && GLOBAL_IRQ_EN_I);
   endproperty
   a_request: assert property (p_request)
      else $error("request does not match flag and enables");

   property p_flag_clear;
      (s_flag_clear_req and !evt) |=> !q.flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag not cleared by ack or write one");

   property p_flag_keep;
      (s_csr_write and !WDATA_I[CSR_FLAG_BIT] and !IRQ_ACK_I)
         |=> q.flag == $past(q.flag) || $past(evt);
   endproperty
   a_flag_keep: assert property (p_flag_keep)
      else $error("writing zero changed the flag");

   property p_power;
      s_csr_write |=> q.pwr_off == $past(WDATA_I[CSR_PWR_BIT]);
   endproperty
   a_power: assert property (p_power)
      else $error("power-off bit not taken from write");

   property p_rsvd_bit;
      (RD_I && ADDR_I == ADDR_CSR) |=> !RDATA_O[2];
   endproperty
   a_rsvd_bit: assert property (p_rsvd_bit)
      else $error("reserved bit reads one");

   property p_buf_off;
      q.didr[DIDR_POS_BIT] |=> !PIN_READ_O[DIDR_POS_BIT];
   endproperty
   a_buf_off: assert property (p_buf_off)
      else $error("disabled pin reads one");

   property p_ctrl_b_read;
      (RD_I && ADDR_I == ADDR_CTRL_B) |=> (RDATA_O & 8'hB8) == 8'h00;
   endproperty
   a_ctrl_b_read: assert property (p_ctrl_b_read)
      else $error("unused bit of register B reads one");
endmodule : cmpc_top
`default_nettype wire

// ==== logic/cmpc_pkg.sv ====
// Summary of operation
// - result is high when selected positive input exceeds selected negative
// - mux select set and converter off: channel pin 0-3 is negative input
// - bandgap select set: fixed reference feeds the positive input
// - raw comparator output is synchronised, two cycles latency
// - interrupt flag is set on the event chosen by the mode bits
// - mode 00 toggle, 01 reserved, 10 falling edge, 11 rising edge
// - request only while flag, enable and global enable are all set
// - flag clears when the processor enters the comparator vector
// - writing one to the flag clears it, writing zero leaves it
// - power-off bit 7 switches the comparator off, zero switches it on
// - reserved bit 2 of the comparator register reads zero
// - buffer-off bits 1 and 0 force the matching pin read to zero
// - converter register B holds bit 6 mux select, bits 2-0 trigger

// ***********************************************************
// register map and field layout
// ***********************************************************
package cmpc_pkg;
   localparam int unsigned LEVEL_W = 10;
   localparam logic [9:0] BANDGAP_LEVEL = 10'h100;
   localparam logic [1:0] ADDR_CTRL_B = 2'h0;
   localparam logic [1:0] ADDR_CSR = 2'h1;
   localparam logic [1:0] ADDR_DIDR = 2'h2;
   localparam int unsigned CSR_PWR_BIT = 7;
   localparam int unsigned CSR_BG_BIT = 6;
   localparam int unsigned CSR_RES_BIT = 5;
   localparam int unsigned CSR_FLAG_BIT = 4;
   localparam int unsigned CSR_IEN_BIT = 3;
   localparam int unsigned CSR_MODE_LO = 0;
   localparam int unsigned CTRLB_MUX_BIT = 6;
   localparam int unsigned CTRLB_TRIG_LO = 0;
   localparam int unsigned DIDR_W = 6;
   localparam int unsigned DIDR_NEG_BIT = 1;
   localparam int unsigned DIDR_POS_BIT = 0;
   localparam logic [2:0] TRIG_RST = 3'h0;
   localparam logic [5:0] DIDR_RST = 6'h00;
   localparam int unsigned SYNC_CYCLES = 2;

   typedef enum logic [1:0] {
      CMPC_MODE_TOGGLE = 2'b00,
      CMPC_MODE_RSVD = 2'b01,
      CMPC_MODE_FALL = 2'b10,
      CMPC_MODE_RISE = 2'b11
   } cmpc_mode_t;

   typedef struct packed {
      logic [1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } cmpc_bus_t;

   typedef struct packed {
      logic mux_sel;
      logic [2:0] trig;
      logic pwr_off;
      logic bg_sel;
      logic flag;
      logic ien;
      cmpc_mode_t mode;
      logic [5:0] didr;
      logic [7:0] rdata;
      logic irq_req;
      logic [1:0] pin_rd;
   } cmpc_state_t;
endpackage : cmpc_pkg

// ==== logic/cmpc_sync.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmpc_sync
   import cmpc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // data
   input wire logic async_i,
   output logic sync_o
);
   logic [1:0] st_q;
   logic [1:0] st_d;

   // first stage feeds only the second stage
   always_comb begin
      st_d = {st_q[0], async_i};
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st_q <= 2'h0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q[1];
endmodule : cmpc_sync
`default_nettype wire

// ==== logic/cmpc_edge.sv ====
`timescale 1ns/1ns
`default_nettype none
module cmpc_edge
   import cmpc_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // sample and mode
   input wire logic sample_i,
   input wire cmpc_mode_t mode_i,
   output logic event_o
);
   typedef struct packed {
      logic prev;
      logic primed;
   } cmpc_edge_st_t;

   cmpc_edge_st_t q;
   cmpc_edge_st_t d;
   logic rise;
   logic fall;

   always_comb begin
      d.prev = sample_i;
      d.primed = 1'b1;
      // no event on the first sample after reset: no valid history yet
      rise = q.primed & sample_i & ~q.prev;
      fall = q.primed & ~sample_i & q.prev;
      unique case (mode_i)
         CMPC_MODE_TOGGLE: event_o = rise | fall;
         CMPC_MODE_RSVD: event_o = 1'b0;
         CMPC_MODE_FALL: event_o = fall;
         CMPC_MODE_RISE: event_o = rise;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   property p_edge_rise;
      @(posedge clk_i) disable iff (!rstn_i)
      (mode_i == CMPC_MODE_RISE) |->
         (event_o == (q.primed && sample_i && !$past(sample_i)));
   endproperty
   a_edge_rise: assert property (p_edge_rise)
      else $error("rising event does not match sample history");
endmodule : cmpc_edge
`default_nettype wire

// ==== sim/cmpc_analog_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ***********************************************************
// analog levels seen at the comparator and channel pins
// ***********************************************************
module cmpc_analog_model
   import cmpc_pkg::*;
(
   // digitised levels
   output logic [9:0] pos_o,
   output logic [9:0] neg_o,
   output logic [9:0] ch0_o,
   output logic [9:0] ch1_o,
   output logic [9:0] ch2_o,
   output logic [9:0] ch3_o
);
   initial begin
      pos_o = 10'h000;
      neg_o = 10'h000;
      ch0_o = 10'h000;
      ch1_o = 10'h000;
      ch2_o = 10'h000;
      ch3_o = 10'h000;
   end

   // callers sit on a rising edge, so levels move just after it
   task automatic set_pn(input logic [9:0] p, input logic [9:0] n);
      pos_o <= p;
      neg_o <= n;
   endtask : set_pn

   task automatic set_ch(input logic [1:0] k, input logic [9:0] v);
      case (k)
         2'h0: ch0_o <= v;
         2'h1: ch1_o <= v;
         2'h2: ch2_o <= v;
         default: ch3_o <= v;
      endcase
   endtask : set_ch
endmodule : cmpc_analog_model
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import cmpc_pkg::*;
;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [1:0] addr = 2'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [7:0] rdata;
   logic [9:0] pos, neg, c0, c1, c2, c3;
   logic conv_en = 1'b0;
   logic [1:0] chan = 2'h0;
   logic gie = 1'b0;
   logic ack = 1'b0;
   logic irq;
   logic [1:0] pin_dig = 2'h0;
   logic [1:0] pin_rd;
   logic res;
   int err_total = 0;
   int checked = 0;

   always #25 clk = ~clk;

   cmpc_analog_model u_ana (.pos_o(pos), .neg_o(neg), .ch0_o(c0),
      .ch1_o(c1), .ch2_o(c2), .ch3_o(c3));

   cmpc_top u_dut (.CLOCK_I(clk), .RSTN_I(rstn), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
      .POS_LEVEL_I(pos), .NEG_LEVEL_I(neg), .CH0_LEVEL_I(c0),
      .CH1_LEVEL_I(c1), .CH2_LEVEL_I(c2), .CH3_LEVEL_I(c3),
      .CONV_ENABLE_I(conv_en), .CHAN_SEL_I(chan),
      .GLOBAL_IRQ_EN_I(gie), .IRQ_ACK_I(ack), .IRQ_REQ_O(irq),
      .PIN_DIG_I(pin_dig), .PIN_READ_O(pin_rd), .RESULT_O(res));

   // ***********************************************************
   // shared helpers
   // ***********************************************************
   task automatic end_of_test();
      $display("checks %0d errors %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc

   task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   // read data stand only in the cycle after the strobe edge
   task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_chk

   task automatic csr(input logic pw, input logic cl, input logic ie,
      input logic [1:0] m);
      wr_reg(ADDR_CSR, {pw, 1'b0, 1'b0, cl, ie, 1'b0, m});
   endtask : csr

   // sync may take two edges; three leaves margin
   task automatic res_chk(input logic e);
      cyc(3);
      #1 chk({7'h00, res}, {7'h00, e});
   endtask : res_chk

   task automatic irq_chk(input logic e);
      cyc(3);
      #1 chk({7'h00, irq}, {7'h00, e});
   endtask : irq_chk

   // ***********************************************************
   // scenarios
   // ***********************************************************
   task automatic t_regs();
      rd_chk(ADDR_CTRL_B, 8'h00);
      rd_chk(ADDR_CSR, 8'h00);
      rd_chk(ADDR_DIDR, 8'h00);
      wr_reg(ADDR_CTRL_B, 8'hFF);
      rd_chk(ADDR_CTRL_B, 8'h47);
      wr_reg(ADDR_CTRL_B, 8'h00);
      wr_reg(ADDR_CSR, 8'h04);
      rd_chk(ADDR_CSR, 8'h00);
      wr_reg(2'h3, 8'hFF);
      rd_chk(2'h3, 8'h00);
   endtask : t_regs

   task automatic t_result();
      @(posedge clk);
      u_ana.set_pn(10'h201, 10'h200);
      cyc(2);
      #1 chk({7'h00, res}, 8'h01);
      @(posedge clk);
      u_ana.set_pn(10'h200, 10'h200);
      res_chk(1'b0);
      wr_reg(ADDR_CSR, 8'h40);
      @(posedge clk);
      u_ana.set_pn(10'h000, BANDGAP_LEVEL - 10'h001);
      res_chk(1'b1);
      @(posedge clk);
      u_ana.set_pn(10'h3FF, BANDGAP_LEVEL + 10'h001);
      res_chk(1'b0);
      csr(1'b0, 1'b1, 1'b0, 2'h0);
   endtask : t_result

   task automatic t_mux();
      wr_reg(ADDR_CTRL_B, 8'h40);
      @(posedge clk);
      u_ana.set_pn(10'h200, 10'h3FF);
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         chan <= 2'(k);
         for (int j = 0; j < 4; j++) begin
            u_ana.set_ch(2'(j), (j == k) ? 10'h000 : 10'h3FF);
         end
         res_chk(1'b1);
      end
      @(posedge clk);
      conv_en <= 1'b1;
      res_chk(1'b0);
      @(posedge clk);
      conv_en <= 1'b0;
      wr_reg(ADDR_CTRL_B, 8'h00);
      res_chk(1'b0);
   endtask : t_mux

   // enable stays off while the mode changes, else spurious events
   task automatic t_modes();
      logic [1:0] m;
      for (int k = 0; k < 4; k++) begin
         m = 2'(k);
         csr(1'b0, 1'b1, 1'b0, m);
         @(posedge clk);
         u_ana.set_pn(10'h300, 10'h200);
         cyc(5);
         rd_chk(ADDR_CSR, {3'b001, m == 2'h0 || m == 2'h3, 2'b00, m});
         csr(1'b0, 1'b1, 1'b0, m);
         @(posedge clk);
         u_ana.set_pn(10'h000, 10'h200);
         cyc(5);
         rd_chk(ADDR_CSR, {3'b000, m == 2'h0 || m == 2'h2, 2'b00, m});
      end
   endtask : t_modes

   task automatic t_irq();
      csr(1'b0, 1'b1, 1'b0, 2'h3);
      @(posedge clk);
      gie <= 1'b1;
      csr(1'b0, 1'b0, 1'b1, 2'h3);
      @(posedge clk);
      u_ana.set_pn(10'h300, 10'h200);
      cyc(3);
      irq_chk(1'b1);
      csr(1'b0, 1'b0, 1'b0, 2'h3);
      irq_chk(1'b0);
      csr(1'b0, 1'b0, 1'b1, 2'h3);
      irq_chk(1'b1);
      @(posedge clk);
      gie <= 1'b0;
      irq_chk(1'b0);
      @(posedge clk);
      gie <= 1'b1;
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      irq_chk(1'b0);
      rd_chk(ADDR_CSR, 8'h2B);
      @(posedge clk);
      u_ana.set_pn(10'h000, 10'h200);
      cyc(4);
      u_ana.set_pn(10'h300, 10'h200);
      cyc(5);
      csr(1'b0, 1'b0, 1'b1, 2'h3);
      rd_chk(ADDR_CSR, 8'h3B);
      csr(1'b0, 1'b1, 1'b1, 2'h3);
      rd_chk(ADDR_CSR, 8'h2B);
      csr(1'b0, 1'b1, 1'b0, 2'h3);
   endtask : t_irq

   task automatic t_power();
      csr(1'b1, 1'b1, 1'b0, 2'h3);
      res_chk(1'b0);
      rd_chk(ADDR_CSR, 8'h83);
      csr(1'b0, 1'b1, 1'b0, 2'h3);
      res_chk(1'b1);
   endtask : t_power

   // analog pins lose their digital buffer to save power
   task automatic t_pins();
      logic [1:0] d;
      @(posedge clk);
      pin_dig <= 2'h3;
      for (int k = 0; k < 4; k++) begin
         d = 2'(k);
         wr_reg(ADDR_DIDR, {6'h00, d});
         cyc(2);
         #1 chk({6'h00, pin_rd}, {6'h00, 2'h3 & ~d});
      end
      wr_reg(ADDR_DIDR, 8'hFF);
      rd_chk(ADDR_DIDR, 8'h3F);
   endtask : t_pins

   // reset in mid run; levels equal so no edge straddles the release
   task automatic t_reset();
      wr_reg(ADDR_CTRL_B, 8'h45);
      @(posedge clk);
      u_ana.set_pn(10'h000, 10'h000);
      rstn <= 1'b0;
      cyc(3);
      rstn <= 1'b1;
      rd_chk(ADDR_CTRL_B, 8'h00);
      cyc(1);
      #1 chk(rdata, 8'h00);
      rd_chk(ADDR_CSR, 8'h00);
      rd_chk(ADDR_DIDR, 8'h00);
      #1 chk({6'h00, pin_rd}, 8'h03);
      chk({7'h00, irq}, 8'h00);
      chk({7'h00, res}, 8'h00);
   endtask : t_reset

   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_regs();
      t_result();
      t_mux();
      t_modes();
      t_irq();
      t_power();
      t_pins();
      t_reset();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
